// ### cocr_top.sv
// Clock output configuration bytes at 0x23 and 0x24 and the output steering they control.
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Differential source: first or third divider.
// - Type field: 00 LVCMOS, 11 HCSL.
// - LVCMOS slew bit: normal or strong.
// - LVCMOS complement output enabled by bit.
// - Power-down bit zero powers chip down.
// - Reference free-run on outputs two, three.
// - Scope bit widens free run to three.
// - Output one: 32k, or fifth/fourth divider.
// - Fourth divider routed to channels two, three.
module cocr_top (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  output logic            o_rvalid,
  input  wire logic       i_first_output_divider_clk,
  input  wire logic       i_third_output_divider_clk,
  input  wire logic       i_fourth_output_divider_clk,
  input  wire logic       i_fifth_output_divider_clk,
  input  wire logic       i_clk_32k,
  input  wire logic       i_ref_clk,
  output logic            o_second_differential_output_a,
  output logic            o_second_differential_output_b,
  output logic            o_second_differential_output_b_en,
  output logic            o_second_differential_output_hcsl,
  output logic            o_second_differential_output_lvcmos,
  output logic            o_second_differential_output_strong_slew,
  output logic            o_chip_powerdown,
  output logic            o_se1,
  output logic            o_se2_ref,
  output logic            o_se3_ref,
  output logic            o_ref_en,
  output logic            o_ch2_fourth_output_divider,
  output logic            o_ch3_fourth_output_divider
);
  logic [7:0] diff_ctrl;
  logic [7:0] pwr_ctrl;
  logic       wr_diff;
  logic       wr_pwr;
  logic [7:0] next_rdata;
  logic       next_rvalid;
  logic       powered;

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Address decode, shared by writes and reads.
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  assign wr_diff = i_wr & hit(i_addr, cocr_pkg::ADDR_DIFF_CTRL);
  assign wr_pwr  = i_wr & hit(i_addr, cocr_pkg::ADDR_PWR_CTRL);

  cocr_reg8 #(
    .RESET_VALUE (cocr_pkg::DIFF_RESET),
    .WRITE_MASK  (cocr_pkg::DIFF_WMASK)
  ) u_diff_ctrl (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_wr    (wr_diff),
    .i_wdata (i_wdata),
    .o_value (diff_ctrl)
  );

  cocr_reg8 #(
    .RESET_VALUE (cocr_pkg::PWR_RESET),
    .WRITE_MASK  (cocr_pkg::PWR_WMASK)
  ) u_pwr_ctrl (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_wr    (wr_pwr),
    .i_wdata (i_wdata),
    .o_value (pwr_ctrl)
  );

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Read data one cycle after the strobe; unmapped addresses return zero.
  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = i_rd;
    if (i_rd) begin
      if (hit(i_addr, cocr_pkg::ADDR_DIFF_CTRL)) begin
        next_rdata = diff_ctrl;
      end else if (hit(i_addr, cocr_pkg::ADDR_PWR_CTRL)) begin
        next_rdata = pwr_ctrl;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_rdata  <= 8'h00;
      o_rvalid <= 1'b0;
    end else begin
      o_rdata  <= next_rdata;
      o_rvalid <= next_rvalid;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks on the layout of the two bytes.
  // The steering below assumes a two-bit format field, two distinct addresses, two distinct
  // format codes and reset values that sit only in writable positions. A change of the
  // constants that breaks one of these would otherwise show up only as odd output behaviour,
  // long after the change was made, so it is refused here instead.

  // The format field is read as one two-bit code.
  if (cocr_pkg::DIFF_TYPE_HI != cocr_pkg::DIFF_TYPE_LO + 1) begin : g_type_width_check
    $error("Format field must be exactly two bits wide.");
  end

  // Both bytes need their own address, or one write would land in both.
  if (cocr_pkg::ADDR_DIFF_CTRL == cocr_pkg::ADDR_PWR_CTRL) begin : g_addr_check
    $error("The two configuration bytes need distinct addresses.");
  end

  // A reset value in a reserved position would be masked away and never seen.
  if ((cocr_pkg::DIFF_RESET & ~cocr_pkg::DIFF_WMASK) != 8'h00) begin : g_diff_reset_check
    $error("Differential byte reset value touches reserved positions.");
  end

  // The same holds for the power byte.
  if ((cocr_pkg::PWR_RESET & ~cocr_pkg::PWR_WMASK) != 8'h00) begin : g_pwr_reset_check
    $error("Power byte reset value touches reserved positions.");
  end

  // Two equal format codes would turn both format flags on at once.
  if (cocr_pkg::TYPE_LVCMOS == cocr_pkg::TYPE_HCSL) begin : g_type_code_check
    $error("Format codes must differ.");
  end

  // The source and power-down bit positions have to fall inside a byte.
  if (cocr_pkg::DIFF_SRC_BIT > 7 || cocr_pkg::PWR_PDN_BIT > 7) begin : g_pos_check
    $error("Field position outside the byte.");
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Field decode.
  // Each field is pulled out of its byte once, by name, so that the steering logic below reads
  // as the behaviour it carries out rather than as bit positions. The field_bit helper is
  // shared by both bytes; diff_type serves the differential byte only.

  // Two-bit output format code of the differential control byte.
  function automatic logic [1:0] diff_type(input logic [7:0] ctrl);
    diff_type = ctrl[cocr_pkg::DIFF_TYPE_HI:cocr_pkg::DIFF_TYPE_LO];
  endfunction

  // One bit of a control byte at a given position.
  function automatic logic field_bit(input logic [7:0] ctrl, input int pos);
    field_bit = ctrl[pos];
  endfunction

  logic [1:0] type_code;
  logic       src_third;
  logic       fmt_lvcmos;
  logic       fmt_hcsl;
  logic       slew_strong;
  logic       comp_on;
  logic       ref_run;
  logic       ref_both;
  logic       se1_divided;
  logic       se1_fourth;
  logic       ref_out_on;
  logic [1:0] ref_allow;
  logic [1:0] ref_route;
  logic [1:0] fourth_output_divider_allow;
  logic [1:0] fourth_output_divider_route;

  // Differential byte fields.
  assign type_code   = diff_type(diff_ctrl);
  assign src_third   = field_bit(diff_ctrl, cocr_pkg::DIFF_SRC_BIT);
  assign fmt_lvcmos  = (type_code == cocr_pkg::TYPE_LVCMOS);
  assign fmt_hcsl    = (type_code == cocr_pkg::TYPE_HCSL);
  assign slew_strong = field_bit(diff_ctrl, cocr_pkg::DIFF_SLEW_BIT);
  assign comp_on     = field_bit(diff_ctrl, cocr_pkg::DIFF_COMP_BIT);

  // Power byte fields.
  assign ref_run     = field_bit(pwr_ctrl, cocr_pkg::PWR_REFRUN_BIT);
  assign ref_both    = field_bit(pwr_ctrl, cocr_pkg::PWR_SCOPE_BIT);
  assign se1_divided = field_bit(pwr_ctrl, cocr_pkg::PWR_32K_BIT);
  assign se1_fourth  = field_bit(pwr_ctrl, cocr_pkg::PWR_SE1SEL_BIT);
  assign ref_out_on  = field_bit(pwr_ctrl, cocr_pkg::PWR_REFEN_BIT);

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Clock steering is combinational: these are clock paths, so registering them would halve them.
  // Every output below is a pure function of the two stored bytes and the incoming source clocks.
  // A short pulse can appear on an output at the moment a byte is rewritten while its sources
  // toggle; the host should reprogram a path only while nothing downstream depends on it.
  //
  // Power-down silences every clock output while the configuration bytes keep their values.
  // Keeping the bytes alive lets the host wake the chip by one write of the power byte alone,
  // without reloading the rest of the configuration.
  assign powered          = pwr_ctrl[cocr_pkg::PWR_PDN_BIT];
  assign o_chip_powerdown = ~powered;

  // Differential output source: first or third divider, silent in power-down.
  always_comb begin
    o_second_differential_output_a = 1'b0;
    if (powered) begin
      o_second_differential_output_a = src_third ? i_third_output_divider_clk : i_first_output_divider_clk;
    end
  end

  // Output format flags. The reserved codes raise neither flag, so the output stage
  // falls back to its quiet state rather than guessing at a format.
  assign o_second_differential_output_hcsl   = fmt_hcsl;
  assign o_second_differential_output_lvcmos = fmt_lvcmos;

  // Slew and complement apply only in LVCMOS; reserved format codes leave both off.
  // The complement is also gated by power so that no clock leaks out in power-down.
  assign o_second_differential_output_strong_slew = fmt_lvcmos & slew_strong;
  assign o_second_differential_output_b_en        = fmt_lvcmos & comp_on & powered;
  assign o_second_differential_output_b           = o_second_differential_output_b_en ? o_second_differential_output_a : 1'b0;

  // First single-ended output: 32k free run by default, else divider choice.
  // The 32k path is the default so that a low-rate clock is present straight after reset.
  always_comb begin
    o_se1 = 1'b0;
    if (powered) begin
      if (!se1_divided) begin
        o_se1 = i_clk_32k;
      end else begin
        o_se1 = se1_fourth ? i_fourth_output_divider_clk : i_fifth_output_divider_clk;
      end
    end
  end

  // Reference free run on outputs two and three; the scope bit decides whether three joins.
  // Output two always joins when free run is on; output three only when the scope is widened.
  assign ref_allow[0] = 1'b1;
  assign ref_allow[1] = ref_both;

  // One identical gate per reference output.
  for (genvar s = 0; s < 2; s++) begin : g_ref_route
    assign ref_route[s] = powered & ref_run & ref_allow[s] & i_ref_clk;
  end

  assign o_se2_ref = ref_route[0];
  assign o_se3_ref = ref_route[1];

  // Reference output enable, also silenced in power-down.
  assign o_ref_en = powered & ref_out_on;

  // Fourth divider routing to channels two and three; each channel has its own enable bit.
  assign fourth_output_divider_allow[0] = field_bit(pwr_ctrl, cocr_pkg::PWR_CH2_BIT);
  assign fourth_output_divider_allow[1] = field_bit(pwr_ctrl, cocr_pkg::PWR_CH3_BIT);

  // One identical gate per channel.
  for (genvar c = 0; c < 2; c++) begin : g_fourth_output_divider_route
    assign fourth_output_divider_route[c] = powered & fourth_output_divider_allow[c] & i_fourth_output_divider_clk;
  end

  assign o_ch2_fourth_output_divider = fourth_output_divider_route[0];
  assign o_ch3_fourth_output_divider = fourth_output_divider_route[1];
endmodule

// ### cocr_pkg.sv
// Package with offsets, field positions, reset values and codes of the clock output configuration bytes.
package cocr_pkg;
  localparam logic [7:0] ADDR_DIFF_CTRL = 8'h23;
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h24;
  // Field positions of the second differential output control byte.
  localparam int DIFF_SRC_BIT   = 7;
  localparam int DIFF_TYPE_HI   = 5;
  localparam int DIFF_TYPE_LO   = 4;
  localparam int DIFF_SLEW_BIT  = 1;
  localparam int DIFF_COMP_BIT  = 0;
  // Field positions of the power and single-ended control byte.
  localparam int PWR_PDN_BIT    = 7;
  localparam int PWR_REFRUN_BIT = 6;
  localparam int PWR_SCOPE_BIT  = 5;
  localparam int PWR_32K_BIT    = 4;
  localparam int PWR_SE1SEL_BIT = 3;
  localparam int PWR_REFEN_BIT  = 2;
  localparam int PWR_CH3_BIT    = 1;
  localparam int PWR_CH2_BIT    = 0;
  // Writable masks; reserved positions stay zero.
  localparam logic [7:0] DIFF_WMASK = 8'hB3;
  localparam logic [7:0] PWR_WMASK  = 8'hFF;
  // Reset values.
  localparam logic [7:0] DIFF_RESET = 8'h30;
  localparam logic [7:0] PWR_RESET  = 8'h8C;
  // Output format codes of the differential output.
  localparam logic [1:0] TYPE_LVCMOS = 2'h0;
  localparam logic [1:0] TYPE_HCSL   = 2'h3;
  // Clock source selection codes.
  typedef enum logic [1:0] {
    cocr_src_32k_t_dummy = 2'h0
  } cocr_unused_t;
endpackage

// ### cocr_reg8.sv
// One masked 8-bit configuration register with synchronous reset.
`timescale 1ns/100ps
module cocr_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00,
  parameter logic [7:0] WRITE_MASK  = 8'hFF
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_value
);
  logic [7:0] next_value;

  // Reserved positions neither store nor return anything but zero.
  always_comb begin
    next_value = o_value;
    if (i_wr) begin
      next_value = i_wdata & WRITE_MASK;
    end
  end

  // Register only.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      o_value <= RESET_VALUE & WRITE_MASK;
    end else begin
      o_value <= next_value;
    end
  end
endmodule

// ### cocr_host.sv
// Host model that programs the configuration bytes one strobe at a time.
`timescale 1ns/100ps
module cocr_host (
  input  wire logic       i_clock,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata
);
  // Idle until the bench asks for a transfer.
  initial begin
    {o_wr, o_rd, o_addr, o_wdata} = '0;
  end
  // One byte per request; released data is inverted so a stale value never passes.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
    @(negedge i_clock);
    {o_wr, o_rd, o_wdata} = {2'h0, ~d};
  endtask
endmodule

// ### cocr_top_assertions.sv
// Checker of the configuration block outputs against the bytes written.
`timescale 1ns/100ps
module cocr_chk (
  input wire logic       i_clock, i_rst_b, i_wr, i_rd, i_first_output_divider_clk, i_third_output_divider_clk, i_fourth_output_divider_clk, i_ref_clk,
  input wire logic [7:0] i_addr, i_wdata, o_rdata,
  input wire logic       o_rvalid, o_second_differential_output_a, o_second_differential_output_hcsl, o_second_differential_output_lvcmos, o_second_differential_output_strong_slew,
  input wire logic       o_chip_powerdown, o_se2_ref, o_se3_ref, o_ch3_fourth_output_divider
);
  // One clock domain, so reset masks every check here.
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  sequence s_wr23; i_wr && i_addr == 8'h23; endsequence
  sequence s_wr24; i_wr && i_addr == 8'h24; endsequence
  property p_src; s_wr23 ##1 !o_chip_powerdown |-> o_second_differential_output_a == ($past(i_wdata[7]) ? i_third_output_divider_clk : i_first_output_divider_clk); endproperty
  a_src: assert property (p_src) else $error("diff source wrong");
  property p_type; s_wr23 |=> o_second_differential_output_hcsl == &$past(i_wdata[5:4]) && o_second_differential_output_lvcmos == !$past(|i_wdata[5:4]); endproperty
  a_type: assert property (p_type) else $error("diff type wrong");
  property p_slew; o_second_differential_output_strong_slew |-> o_second_differential_output_lvcmos; endproperty
  a_slew: assert property (p_slew) else $error("slew outside lvcmos");
  property p_pdn; s_wr24 |=> o_chip_powerdown == !$past(i_wdata[7]); endproperty
  a_pdn: assert property (p_pdn) else $error("powerdown wrong");
  property p_se2; o_se2_ref |-> i_ref_clk && !o_chip_powerdown; endproperty
  a_se2: assert property (p_se2) else $error("ref on out2 wrong");
  property p_se3; o_se3_ref |-> o_se2_ref; endproperty
  a_se3: assert property (p_se3) else $error("ref on out3 wrong");
  property p_ch3; s_wr24 |=> o_ch3_fourth_output_divider == (i_fourth_output_divider_clk && $past(i_wdata[1]) && $past(i_wdata[7])); endproperty
  a_ch3: assert property (p_ch3) else $error("channel 3 wrong");
  property p_rsv; i_rd && i_addr == 8'h23 |=> o_rvalid && (o_rdata & 8'h4C) == 8'h00; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read back");
endmodule
bind cocr_top cocr_chk u_chk (.*);

// ### tb.sv
// Self-checking bench for the clock output configuration block.
`timescale 1ns/100ps
module tb;
  logic       i_clock = 1'b0;
  logic       i_rst_b = 1'b0;
  logic       wr, rd, o_rvalid, a, hcsl, lvc, slew, b_en, pd, se1, se3, ch2, ch3, se2, ref_en, b;
  logic [7:0] addr, wdata, o_rdata, d3, d4;
  logic [7:0] r = 8'h57;
  logic [5:0] clks = 6'h00;
  logic [7:0] exq[$];
  int         err_count = 0;
  int         n_tests = 0;
  cocr_host u_host (.i_clock(i_clock), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata));
  cocr_top DUT (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_wr(wr), .i_rd(rd), .i_addr(addr), .i_wdata(wdata),
    .o_rdata(o_rdata), .o_rvalid(o_rvalid), .i_first_output_divider_clk(clks[5]), .i_third_output_divider_clk(clks[4]), .i_fourth_output_divider_clk(clks[3]),
    .i_fifth_output_divider_clk(clks[2]), .i_clk_32k(clks[1]), .i_ref_clk(clks[0]), .o_second_differential_output_a(a), .o_second_differential_output_b(b),
    .o_second_differential_output_b_en(b_en), .o_second_differential_output_hcsl(hcsl), .o_second_differential_output_lvcmos(lvc), .o_second_differential_output_strong_slew(slew),
    .o_chip_powerdown(pd), .o_se1(se1), .o_se2_ref(se2), .o_se3_ref(se3), .o_ref_en(ref_en), .o_ch2_fourth_output_divider(ch2),
    .o_ch3_fourth_output_divider(ch3));
  // Free-running 200 MHz clock.
  always #2.5 i_clock = ~i_clock;
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(input string n, input logic e, input logic g);
    chk(n, {7'h00, e}, {7'h00, g});
  endtask
  task automatic rd8(input logic [7:0] ad, input logic [7:0] e);
    exq.push_back(e);
    u_host.xfer(1'b0, ad, 8'h00);
  endtask
  // Fresh random source clocks, then every steered output against the two bytes.
  task automatic outs(input logic [7:0] c, input logic [7:0] p);
    @(negedge i_clock);
    clks = r[5:0];
    r = lfsr(r);
    #1;
    chk1("pdn", !p[7], pd);
    chk1("diff_a", p[7] & (c[7] ? clks[4] : clks[5]), a);
    chk1("lvcmos", c[5:4] == 2'h0, lvc);
    chk1("hcsl", c[5:4] == 2'h3, hcsl);
    chk1("slew", c[5:4] == 2'h0 && c[1], slew);
    chk1("b_en", p[7] && c[5:4] == 2'h0 && c[0], b_en);
    chk1("diff_b", p[7] && c[5:4] == 2'h0 && c[0] && (c[7] ? clks[4] : clks[5]), b);
    chk1("se2", p[7] & clks[0] & p[6], se2);
    chk1("ref_en", p[7] & p[2], ref_en);
    chk1("se3", p[7] & clks[0] & p[6] & p[5], se3);
    chk1("se1", p[7] & (p[4] ? (p[3] ? clks[3] : clks[2]) : clks[1]), se1);
    chk1("ch3", p[7] & clks[3] & p[1], ch3);
    chk1("ch2", p[7] & clks[3] & p[0], ch2);
  endtask
  task automatic test_done;
    if (exq.size() != 0) begin
      err_count++;
      $display("ERROR pending_reads expected 0 seen %0d", exq.size());
    end
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // Read results are paired with the oldest expectation once the valid pulse has settled.
  always @(negedge i_clock) if (o_rvalid === 1'b1) chk("rdata", exq.pop_front(), o_rdata);
  // The whole sequence needs under 3000 cycles; four times that means a hang.
  initial begin
    #60000;
    err_count++;
    test_done();
  end
  // Reset values, random programming with every type code, unmapped access, then a second reset.
  initial begin
    repeat (3) @(negedge i_clock);
    i_rst_b = 1'b1;
    rd8(8'h23, cocr_pkg::DIFF_RESET);
    rd8(8'h24, cocr_pkg::PWR_RESET);
    outs(cocr_pkg::DIFF_RESET, cocr_pkg::PWR_RESET);
    $display("reset test done");
    for (int k = 0; k < 40; k++) begin
      d3 = r;
      d3[5:4] = k[1:0];
      d4 = lfsr(r);
      r = lfsr(d4);
      u_host.xfer(1'b1, 8'h23, d3);
      u_host.xfer(1'b1, 8'h24, d4);
      rd8(8'h23, d3 & cocr_pkg::DIFF_WMASK);
      rd8(8'h24, d4);
      outs(d3 & cocr_pkg::DIFF_WMASK, d4);
    end
    $display("random test done");
    u_host.xfer(1'b1, 8'h25, 8'hFF);
    rd8(8'h25, 8'h00);
    rd8(8'h24, d4);
    $display("unmapped test done");
    i_rst_b = 1'b0;
    @(negedge i_clock);
    i_rst_b = 1'b1;
    rd8(8'h24, cocr_pkg::PWR_RESET);
    @(negedge i_clock);
    $display("second reset test done");
    test_done();
  end
endmodule
